// >>> include/hbr_pkg.sv
// Purpose: shared constants and carriers for the bridge command/status pair
// Assumes: config accesses are dword wide with byte enables
// Notes: byte addresses; command and status share one dword
package hbr_pkg;

    // config space layout
    localparam logic [7:0] CMD_OFFSET = 8'h04;
    localparam logic [7:0] STS_OFFSET = 8'h06;
    localparam logic [7:0] CMDSTS_DWORD = 8'h04;
    localparam int STS_SHIFT = 16;

    // command register fields
    localparam int CMD_FAST_B2B = 9;
    localparam int CMD_SERR_EN = 8;
    localparam int CMD_STEPPING = 7;
    localparam int CMD_PARITY_EN = 6;
    localparam int CMD_PALETTE = 5;
    localparam int CMD_WR_INVAL = 4;
    localparam int CMD_SPECIAL = 3;
    localparam int CMD_BUS_MASTER = 2;
    localparam int CMD_MEM_ACCESS = 1;
    localparam int CMD_IO_ACCESS = 0;
    localparam logic [15:0] CMD_RESET = 16'h0006;
    localparam logic [15:0] CMD_FIXED = 16'h0006;

    // status register fields
    localparam int STS_DET_PARITY = 15;
    localparam int STS_SIG_SERR = 14;
    localparam int STS_RX_MASTER_ABORT = 13;
    localparam int STS_RX_TARGET_ABORT = 12;
    localparam int STS_SIG_TARGET_ABORT = 11;
    localparam int STS_SEL_TIMING_HI = 10;
    localparam int STS_SEL_TIMING_LO = 9;
    localparam int STS_MASTER_PARITY = 8;
    localparam int STS_FAST_B2B = 7;
    localparam int STS_CAP_LIST = 4;
    localparam logic [15:0] STS_RESET = 16'h0090;
    localparam logic [15:0] STS_FIXED = 16'h0090;
    localparam logic [1:0] SEL_TIMING_FAST = 2'h0;

    // sticky flag slots, all in status byte lane 3 of the dword
    localparam int NUM_FLAGS = 5;
    localparam int FLAG_DPE = 0;
    localparam int FLAG_SSE = 1;
    localparam int FLAG_RMA = 2;
    localparam int FLAG_RTA = 3;
    localparam int FLAG_MDPE = 4;
    localparam logic [NUM_FLAGS-1:0][3:0] FLAG_POS = {4'h8, 4'hc, 4'hd, 4'he, 4'hf};
    localparam int FLAG_LANE = 3;

    typedef struct packed {
        logic req;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } hbr_cfg_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } hbr_cfg_rsp_t;

    typedef struct packed {
        logic poisoned_tlp;
        logic unsupported_cpl;
        logic abort_cpl;
        logic poisoned_cpl;
        logic error_condition;
    } hbr_evt_t;

endpackage

// >>> verilog/hbr_flag.sv
// Purpose: one sticky write-one-to-clear status flag
// Assumes: set and clear are single-cycle strobes on clock
// Notes: a set in the clear cycle keeps the flag
`timescale 1ns/1ps
`default_nettype none
module hbr_flag (
    input wire logic clock,
    input wire logic nrst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    typedef struct packed {
        logic flag;
    } hbr_flag_st_t;

    hbr_flag_st_t st_q;
    hbr_flag_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (set) begin
            st_d.flag = 1'b1;
        end else if (clr) begin
            st_d.flag = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.flag;
endmodule
`default_nettype wire

// >>> verilog/hbr_serr_tx.sv
// Purpose: raises one system-error message request toward the link
// Assumes: ready comes from link logic on the same clock
// Notes: triggers while a message waits for ready merge into it; one in the cycle it is taken raises another
`timescale 1ns/1ps
`default_nettype none
module hbr_serr_tx (
    input wire logic clock,
    input wire logic nrst,
    input wire logic enable,
    input wire logic trigger,
    output logic msg_valid,
    input wire logic msg_ready,
    output logic sent
);
    typedef struct packed {
        logic pending;
    } hbr_serr_st_t;

    hbr_serr_st_t st_q;
    hbr_serr_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (!enable) begin
            st_d.pending = 1'b0;
        end else if (trigger) begin
            st_d.pending = 1'b1;
        end else if (st_q.pending && msg_ready) begin
            st_d.pending = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // nothing leaves while the enable is low
    assign msg_valid = st_q.pending && enable;
    assign sent = msg_valid && msg_ready;
endmodule
`default_nettype wire

// >>> verilog/hbr_cmdsts.sv
// Purpose: bridge command and status register pair of function 0
// Assumes: config port and event strobes are on clock
// Notes: command in dword lanes 1:0, status in lanes 3:2
//
// Behaviour
// R1: command bit 9 reads 0, writes ignored; fast back-to-back is never enabled.
// R2: with system-error enable set, send a message per enabled error condition; conditions arriving while a message waits for ready merge into it.
// R3: with system-error enable clear, never send a system-error message.
// R4: message path active when own enable or function 1 enable set.
// R5: command bit 7 stepping enable reads 0.
// R6: parity error enable is read/write, reset 0, gates master parity flag.
// R7: command bits 5 and 4 read 0; no write-and-invalidate is issued.
// R8: command bit 3 reads 0, writes have no effect.
// R9: command bit 2 bus master enable reads 1.
// R10: command bit 1 memory access enable reads 1 regardless of writes.
// R11: command bit 0 io access enable reads 0.
// R12: status bit 15 sets on a received poisoned packet; write 1 clears.
// R13: status bit 14 sets when a system-error message is sent; write 1 clears.
// R14: status bit 13 sets on an unsupported request completion; write 1 clears.
// R15: status bit 12 sets on a completer abort completion; write 1 clears.
// R16: status bit 11 reads 0; no target abort is ever signalled.
// R17: status bits 10:9 read 00, fast decode; writes ignored.
// R18: status bit 8 sets on poisoned completion only while parity enable set.
// R19: status bit 7 reads 1, fast back-to-back capable.
// R20: status bit 4 reads 1, capability list present.
// R21: read-only and reserved bits ignore writes; reserved bits read 0.
`timescale 1ns/1ps
`default_nettype none
module hbr_cmdsts (
    input wire logic clock,
    input wire logic nrst,
    input wire hbr_pkg::hbr_cfg_req_t cfg_req,
    output hbr_pkg::hbr_cfg_rsp_t cfg_rsp,
    input wire hbr_pkg::hbr_evt_t events,
    input wire logic fn1_serr_enable,
    output logic serr_path_active,
    output logic serr_msg_valid,
    input wire logic serr_msg_ready,
    output logic system_error_enable,
    output logic parity_error_enable,
    output logic write_invalidate_enable
);
    typedef struct packed {
        logic serr_en;
        logic parity_en;
        logic ack;
        logic [31:0] rdata;
    } hbr_main_st_t;

    hbr_main_st_t st_q;
    hbr_main_st_t st_d;

    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic serr_sent;
    logic [hbr_pkg::NUM_FLAGS-1:0] flag_set;
    logic [hbr_pkg::NUM_FLAGS-1:0] flag_clr;
    logic [hbr_pkg::NUM_FLAGS-1:0] flag_q;
    logic [15:0] cmd_view;
    logic [15:0] sts_view;
    logic [31:0] dword_view;

    // decode of the shared dword
    always_comb begin
        hit = 1'b0;
        if (cfg_req.req && (cfg_req.addr[7:2] == hbr_pkg::CMDSTS_DWORD[7:2])) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    assign wr_hit = hit && cfg_req.wr;
    assign rd_hit = hit && !cfg_req.wr;

    // system-error message sender, gated by own enable
    hbr_serr_tx u_serr_tx (
        .clock(clock),
        .nrst(nrst),
        .enable(st_q.serr_en), // R3
        .trigger(events.error_condition && st_q.serr_en), // R2
        .msg_valid(serr_msg_valid),
        .msg_ready(serr_msg_ready),
        .sent(serr_sent)
    );

    // flag set sources
    always_comb begin
        flag_set = '0;
        flag_set[hbr_pkg::FLAG_DPE] = events.poisoned_tlp; // R12
        flag_set[hbr_pkg::FLAG_SSE] = serr_sent; // R13
        flag_set[hbr_pkg::FLAG_RMA] = events.unsupported_cpl; // R14
        flag_set[hbr_pkg::FLAG_RTA] = events.abort_cpl; // R15
        flag_set[hbr_pkg::FLAG_MDPE] = events.poisoned_cpl && st_q.parity_en; // R6 R18
    end

    // write-one-to-clear strobes and sticky flags
    genvar gi;
    generate
        for (gi = 0; gi < hbr_pkg::NUM_FLAGS; gi++) begin : g_flag
            assign flag_clr[gi] = wr_hit && cfg_req.be[hbr_pkg::FLAG_LANE]
                && cfg_req.wdata[hbr_pkg::STS_SHIFT + int'(hbr_pkg::FLAG_POS[gi])]; // R13
            hbr_flag u_flag (
                .clock(clock),
                .nrst(nrst),
                .set(flag_set[gi]),
                .clr(flag_clr[gi]),
                .q(flag_q[gi])
            );
        end
    endgenerate

    // command read view
    always_comb begin
        cmd_view = hbr_pkg::CMD_FIXED; // R21
        cmd_view[hbr_pkg::CMD_FAST_B2B] = 1'b0; // R1
        cmd_view[hbr_pkg::CMD_SERR_EN] = st_q.serr_en;
        cmd_view[hbr_pkg::CMD_STEPPING] = 1'b0; // R5
        cmd_view[hbr_pkg::CMD_PARITY_EN] = st_q.parity_en; // R6
        cmd_view[hbr_pkg::CMD_PALETTE] = 1'b0; // R7
        cmd_view[hbr_pkg::CMD_WR_INVAL] = 1'b0; // R7
        cmd_view[hbr_pkg::CMD_SPECIAL] = 1'b0; // R8
        cmd_view[hbr_pkg::CMD_BUS_MASTER] = 1'b1; // R9
        cmd_view[hbr_pkg::CMD_MEM_ACCESS] = 1'b1; // R10
        cmd_view[hbr_pkg::CMD_IO_ACCESS] = 1'b0; // R11
    end

    // status read view
    always_comb begin
        sts_view = hbr_pkg::STS_FIXED; // R21
        sts_view[hbr_pkg::STS_DET_PARITY] = flag_q[hbr_pkg::FLAG_DPE];
        sts_view[hbr_pkg::STS_SIG_SERR] = flag_q[hbr_pkg::FLAG_SSE];
        sts_view[hbr_pkg::STS_RX_MASTER_ABORT] = flag_q[hbr_pkg::FLAG_RMA];
        sts_view[hbr_pkg::STS_RX_TARGET_ABORT] = flag_q[hbr_pkg::FLAG_RTA];
        sts_view[hbr_pkg::STS_SIG_TARGET_ABORT] = 1'b0; // R16
        sts_view[hbr_pkg::STS_SEL_TIMING_HI:hbr_pkg::STS_SEL_TIMING_LO] =
            hbr_pkg::SEL_TIMING_FAST; // R17
        sts_view[hbr_pkg::STS_MASTER_PARITY] = flag_q[hbr_pkg::FLAG_MDPE];
        sts_view[hbr_pkg::STS_FAST_B2B] = 1'b1; // R19
        sts_view[hbr_pkg::STS_CAP_LIST] = 1'b1; // R20
    end

    assign dword_view = {sts_view, cmd_view};

    // register state and read answer
    always_comb begin
        st_d = st_q;
        st_d.ack = cfg_req.req;
        st_d.rdata = '0;
        if (wr_hit && cfg_req.be[1]) begin
            st_d.serr_en = cfg_req.wdata[hbr_pkg::CMD_SERR_EN];
        end
        if (wr_hit && cfg_req.be[0]) begin
            st_d.parity_en = cfg_req.wdata[hbr_pkg::CMD_PARITY_EN]; // R6
        end
        if (rd_hit) begin
            st_d.rdata = dword_view;
        end else begin
            st_d.rdata = '0; // R21
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cfg_rsp.ack = st_q.ack;
    assign cfg_rsp.rdata = st_q.rdata;
    assign serr_path_active = st_q.serr_en || fn1_serr_enable; // R4
    assign system_error_enable = st_q.serr_en;
    assign parity_error_enable = st_q.parity_en;
    assign write_invalidate_enable = 1'b0; // R7
endmodule
`default_nettype wire

// >>> tb/hbr_cmdsts_checker.sv
// Purpose: port checks for hbr_cmdsts
// Assumes: one clock, async active-low reset
// Notes: bound to every hbr_cmdsts instance
`timescale 1ns/1ps
`default_nettype none
module hbr_cmdsts_checker (
    input wire logic clock,
    input wire logic nrst,
    input wire hbr_pkg::hbr_cfg_req_t cfg_req,
    input wire hbr_pkg::hbr_cfg_rsp_t cfg_rsp,
    input wire hbr_pkg::hbr_evt_t events,
    input wire logic fn1_serr_enable,
    input wire logic serr_path_active,
    input wire logic serr_msg_valid,
    input wire logic serr_msg_ready,
    input wire logic system_error_enable,
    input wire logic parity_error_enable,
    input wire logic write_invalidate_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic rd_hit;
    assign rd_hit = cfg_req.req && !cfg_req.wr && cfg_req.addr[7:2] == 6'h01;
    cmd_fixed_a:
    assert property (rd_hit |=> (cfg_rsp.rdata[15:0] & 16'hfebf) == 16'h0006)
        else $error("command fixed bits wrong");
    sts_fixed_a:
    assert property (rd_hit |=> (cfg_rsp.rdata[31:16] & 16'h0eff) == 16'h0090)
        else $error("status fixed bits wrong");
    enables_read_a:
    assert property (rd_hit |=> cfg_rsp.rdata[8] == $past(system_error_enable)
        && cfg_rsp.rdata[6] == $past(parity_error_enable))
        else $error("enable bits read wrong");
    unmapped_zero_a:
    assert property (cfg_rsp.ack && !$past(rd_hit) |-> cfg_rsp.rdata == 32'h0)
        else $error("non-read data not zero");
    path_or_a:
    assert property (serr_path_active == (system_error_enable || fn1_serr_enable))
        else $error("path active not or of enables");
    serr_off_a:
    assert property (!system_error_enable |-> !serr_msg_valid)
        else $error("message while disabled");
    serr_raise_a:
    assert property (events.error_condition && system_error_enable
        && !(cfg_req.req && cfg_req.wr) |=> serr_msg_valid)
        else $error("message not raised");
    serr_hold_a:
    assert property (serr_msg_valid && !serr_msg_ready |=> serr_msg_valid
        || !system_error_enable)
        else $error("message dropped");
    wr_inval_a:
    assert property (!write_invalidate_enable)
        else $error("write invalidate enabled");
    sse_set_a:
    assert property (serr_msg_valid && serr_msg_ready ##1 rd_hit |=> cfg_rsp.rdata[30])
        else $error("sent flag not set");
    cover property (serr_msg_valid && serr_msg_ready);
    cover property (serr_msg_valid && !serr_msg_ready);
    cover property (events.poisoned_cpl && parity_error_enable);
endmodule
bind hbr_cmdsts hbr_cmdsts_checker chk (.clock, .nrst, .cfg_req, .cfg_rsp, .events,
    .fn1_serr_enable, .serr_path_active, .serr_msg_valid, .serr_msg_ready,
    .system_error_enable, .parity_error_enable, .write_invalidate_enable);
`default_nettype wire

// >>> tb/hbr_link_model.sv
// Purpose: link side taking system-error messages
// Assumes: slow selects a three-cycle stall
// Notes: ready only while a message is offered
`timescale 1ns/1ps
`default_nettype none
module hbr_link_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic slow,
    input wire logic msg_valid,
    output logic msg_ready
);
    logic [1:0] wait_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 2'h0;
        end else begin
            wait_q <= (msg_valid && !msg_ready) ? wait_q + 2'h1 : 2'h0;
        end
    end
    assign msg_ready = msg_valid && (!slow || wait_q == 2'h3);
endmodule
`default_nettype wire

// >>> tb/test_hbr_cmdsts.sv
// Purpose: bench for hbr_cmdsts
// Assumes: link model answers messages
// Notes: dword config accesses only
`timescale 1ns/1ps
`default_nettype none
module test_hbr_cmdsts;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    hbr_pkg::hbr_cfg_req_t cfg_req = '0;
    hbr_pkg::hbr_cfg_rsp_t cfg_rsp;
    hbr_pkg::hbr_evt_t events = '0;
    logic fn1 = 1'b0;
    logic slow = 1'b0;
    logic path, valid, ready, serr_en, par_en, wi_en;
    logic [31:0] rd;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #50 clock = ~clock;
    hbr_cmdsts dut (.clock(clock), .nrst(nrst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
        .events(events), .fn1_serr_enable(fn1), .serr_path_active(path),
        .serr_msg_valid(valid), .serr_msg_ready(ready), .system_error_enable(serr_en),
        .parity_error_enable(par_en), .write_invalidate_enable(wi_en));
    hbr_link_model link (.clock(clock), .nrst(nrst), .slow(slow), .msg_valid(valid),
        .msg_ready(ready));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] wd);
        @(posedge clock);
        cfg_req <= '{1'b1, wr, a, be, wd};
        @(posedge clock);
        cfg_req.req <= 1'b0;
        #1;
        chk("ack", 32'h1, {31'h0, cfg_rsp.ack});
        rd = cfg_rsp.rdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        cfg(1'b0, a, 4'hf, 32'h0);
        chk("rdata", exp, rd);
    endtask
    task automatic pulse(input hbr_pkg::hbr_evt_t e);
        @(posedge clock);
        events <= e;
        @(posedge clock);
        events <= '0;
    endtask
    task automatic serr_wait;
        #1;
        for (int i = 0; i < 20; i++) begin
            if (valid === 1'b1 && ready === 1'b1) break;
            @(posedge clock);
            #1;
        end
        chk("msg_taken", 32'h1, {31'h0, valid && ready});
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            end_of_test;
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        rdchk(8'h04, 32'h0090_0006);
        cfg(1'b1, 8'h04, 4'hf, 32'hffff_ffff);
        rdchk(8'h04, 32'h0090_0146);
        chk("enables", 32'h3, {30'h0, serr_en, par_en});
        chk("wr_inval", 32'h0, {31'h0, wi_en});
        rdchk(8'h08, 32'h0);
        cfg(1'b1, 8'h00, 4'hf, 32'h0);
        rdchk(8'h06, 32'h0090_0146);
        cfg(1'b1, 8'h04, 4'h1, 32'h0);
        pulse(5'h02);
        rdchk(8'h04, 32'h0090_0106);
        cfg(1'b1, 8'h04, 4'h1, 32'h40);
        pulse(5'h1e);
        rdchk(8'h04, 32'hb190_0146);
        cfg(1'b1, 8'h04, 4'h4, 32'hffff_0000);
        cfg(1'b1, 8'h04, 4'h8, 32'ha100_0000);
        rdchk(8'h04, 32'h1090_0146);
        pulse(5'h01);
        serr_wait;
        rdchk(8'h04, 32'h5090_0146);
        @(posedge clock);
        slow <= 1'b1;
        cfg(1'b1, 8'h04, 4'h8, 32'h5000_0000);
        pulse(5'h01);
        serr_wait;
        rdchk(8'h04, 32'h4090_0146);
        cfg(1'b1, 8'h04, 4'ha, 32'h4000_0000);
        @(posedge clock);
        fn1 <= 1'b1;
        pulse(5'h01);
        rdchk(8'h04, 32'h0090_0046);
        chk("path", 32'h1, {31'h0, path});
        chk("msg_valid", 32'h0, {31'h0, valid});
        @(posedge clock);
        fn1 <= 1'b0;
        #1;
        chk("path", 32'h0, {31'h0, path});
        end_of_test;
    end
endmodule
`default_nettype wire
